/* include/ubss_regs.svh */
`ifndef UBSS_REGS_SVH
`define UBSS_REGS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define UBSS_BAUD_RATE_CONTROL_OFS 8'h9b
`define UBSS_BAUD_RATE_CONTROL_RST 8'h00
`define UBSS_TIMER_TWO_CONTROL_OFS 8'hc8
`define UBSS_TIMER_TWO_CONTROL_RST 8'h00
`define UBSS_STATUS_OFS 8'hf0
// ----------------------------------------
// field positions
// ----------------------------------------
`define UBSS_BIT_RUN 4
`define UBSS_BIT_TX_SEL 3
`define UBSS_BIT_RX_SEL 2
`define UBSS_BIT_SPEED 1
`define UBSS_BIT_SHIFT_SEL 0
`define UBSS_DEFINED_MASK 8'h1f
`define UBSS_BIT_T2_RCLK 5
`define UBSS_BIT_T2_TCLK 4
`define UBSS_BIT_T2_X2 0
// ----------------------------------------
// timing counts
// ----------------------------------------
`define UBSS_OSC_DIV 12
`define UBSS_X2_DIV 6
`define UBSS_FAST_DIV 16
`define UBSS_SLOW_DIV 96
`endif

/* include/ubss_pkg.sv */
package ubss_pkg;
  typedef enum logic [1:0] {
    UBSS_IDLE = 2'b00,
    UBSS_WAIT = 2'b01,
    UBSS_DONE = 2'b11
  } ubss_bus_state_t;
endpackage : ubss_pkg

/* rtl/ubss_divider.sv */
`timescale 1ns/1ps
module ubss_divider #(
  parameter int WIDTH = 8
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic enable_in,
  input wire logic [WIDTH-1:0] divide_in,
  output logic tick_out
);
  logic [WIDTH-1:0] count_reg;
  wire logic wrap = (count_reg >= divide_in - {{(WIDTH-1){1'b0}}, 1'b1});
  // halted divider holds its phase at zero so restart is clean
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count_reg <= '0;
      tick_out <= 1'b0;
    end else if (!enable_in) begin
      count_reg <= '0;
      tick_out <= 1'b0;
    end else begin
      count_reg <= wrap ? '0 : count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      tick_out <= wrap;
    end
  end
endmodule : ubss_divider

/* rtl/ubss_top.sv */
`timescale 1ns/1ps
`include "ubss_regs.svh"
// Operation
// R01: run bit starts or stops rate generator
// R02: tx and rx select timer or generator
// R03: speed bit picks slow or fast range
// R04: mode 0 source zero: osc/12, x2 /6
// R05: mode 0 source one: internal generator
// R06: reserved bits unwritten, read undefined
// R07: reset clears defined bits; whole-byte access
// R08: timer path picks timer 2 or 1
module ubss_top (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic timer1_overflow_in,
  input wire logic timer2_overflow_in,
  output logic tx_rate_tick_out,
  output logic rx_rate_tick_out,
  output logic shift_clock_tick_out,
  output logic rate_gen_tick_out
);
  // ----------------------------------------
  // register bus
  // ----------------------------------------
  ubss_pkg::ubss_bus_state_t state_reg;
  ubss_pkg::ubss_bus_state_t state_next;
  logic [4:0] control_reg;
  logic [7:0] timer_two_control_reg;
  wire logic access = avs_read_in | avs_write_in;
  wire logic sel_ctrl = (avs_address_in == `UBSS_BAUD_RATE_CONTROL_OFS);
  wire logic sel_t2 = (avs_address_in == `UBSS_TIMER_TWO_CONTROL_OFS);
  wire logic sel_stat = (avs_address_in == `UBSS_STATUS_OFS);
  wire logic accept = access && (state_reg == ubss_pkg::UBSS_WAIT);
  // whole-byte access only: lane 0 must be enabled
  wire logic wr_ok = accept && avs_write_in && avs_byteenable_in[0]; // R07
  // reserved bits are never stored, so software cannot set them
  wire logic [4:0] ctrl_wdata = avs_writedata_in[4:0]; // R06
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ubss_pkg::UBSS_IDLE: state_next = access ? ubss_pkg::UBSS_WAIT : ubss_pkg::UBSS_IDLE;
      ubss_pkg::UBSS_WAIT: state_next = ubss_pkg::UBSS_DONE;
      ubss_pkg::UBSS_DONE: state_next = ubss_pkg::UBSS_IDLE;
      default: state_next = ubss_pkg::UBSS_IDLE;
    endcase
  end
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= ubss_pkg::UBSS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      control_reg <= 5'h00; // R07
      timer_two_control_reg <= `UBSS_TIMER_TWO_CONTROL_RST;
    end else if (wr_ok && sel_ctrl) begin
      control_reg <= ctrl_wdata;
    end else if (wr_ok && sel_t2) begin
      timer_two_control_reg <= avs_writedata_in[7:0];
    end
  end
  // ----------------------------------------
  // clock selection
  // ----------------------------------------
  wire logic run = control_reg[`UBSS_BIT_RUN];
  wire logic speed = control_reg[`UBSS_BIT_SPEED];
  wire logic tx_sel = control_reg[`UBSS_BIT_TX_SEL];
  wire logic rx_sel = control_reg[`UBSS_BIT_RX_SEL];
  wire logic shift_sel = control_reg[`UBSS_BIT_SHIFT_SEL];
  wire logic double_speed_mode = timer_two_control_reg[`UBSS_BIT_T2_X2];
  wire logic [7:0] gen_div = speed ? 8'(`UBSS_FAST_DIV) : 8'(`UBSS_SLOW_DIV); // R03
  wire logic [7:0] osc_div = double_speed_mode ? 8'(`UBSS_X2_DIV) : 8'(`UBSS_OSC_DIV); // R04
  logic gen_tick;
  logic osc_tick;
  ubss_divider #(.WIDTH(8)) u_rate_gen (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .enable_in(run), // R01
    .divide_in(gen_div),
    .tick_out(gen_tick)
  );
  ubss_divider #(.WIDTH(8)) u_osc_div (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .enable_in(1'b1),
    .divide_in(osc_div),
    .tick_out(osc_tick)
  );
  wire logic tx_timer = timer_two_control_reg[`UBSS_BIT_T2_TCLK] ?
    timer2_overflow_in : timer1_overflow_in; // R08
  wire logic rx_timer = timer_two_control_reg[`UBSS_BIT_T2_RCLK] ?
    timer2_overflow_in : timer1_overflow_in; // R08
  wire logic tx_next = tx_sel ? gen_tick : tx_timer; // R02
  wire logic rx_next = rx_sel ? gen_tick : rx_timer; // R02
  wire logic sh_next = shift_sel ? gen_tick : osc_tick; // R05
  // ----------------------------------------
  // read data and outputs
  // ----------------------------------------
  // reserved bits read as zero, one legal choice of the undefined value
  wire logic [7:0] ctrl_rd = {3'b000, control_reg}; // R06
  wire logic [7:0] stat_rd = {2'b00, tx_sel, rx_sel, run, speed, double_speed_mode, shift_sel};
  wire logic [7:0] rd_mux = sel_ctrl ? ctrl_rd : sel_t2 ? timer_two_control_reg :
    sel_stat ? stat_rd : 8'h00;
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
      avs_waitrequest_out <= 1'b1;
      tx_rate_tick_out <= 1'b0;
      rx_rate_tick_out <= 1'b0;
      shift_clock_tick_out <= 1'b0;
      rate_gen_tick_out <= 1'b0;
    end else begin
      avs_readdata_out <= accept && avs_read_in ? {24'h000000, rd_mux} : 32'h0000_0000;
      avs_waitrequest_out <= !accept;
      tx_rate_tick_out <= tx_next;
      rx_rate_tick_out <= rx_next;
      shift_clock_tick_out <= sh_next;
      rate_gen_tick_out <= gen_tick;
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_gen_halted: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R01
    !run [*3] |-> !rate_gen_tick_out) else $error("generator ticks while halted");
  chk_tx_source: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R02
    tx_rate_tick_out == $past(tx_next)) else $error("tx source wrong");
  chk_rx_gen: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R02
    $past(rx_sel) && $past(gen_tick) |-> rx_rate_tick_out) else $error("rx source wrong");
  sequence s_fast_tick;
    run && speed && gen_tick;
  endsequence
  chk_fast_period: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R03
    s_fast_tick ##1 (run && speed) [*8] |-> !gen_tick) else $error("fast period wrong");
  chk_osc_div: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R04
    osc_tick && !double_speed_mode |=> !osc_tick [*5]) else $error("osc division wrong");
  chk_shift_gen: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R05
    shift_sel && gen_tick |=> shift_clock_tick_out) else $error("shift source wrong");
  chk_reserved_zero: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R06
    !avs_waitrequest_out |-> avs_readdata_out[31:5] == 27'h0 || !$past(sel_ctrl))
    else $error("reserved bits set");
  chk_write_timing: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R07
    wr_ok && sel_ctrl |=> control_reg == $past(ctrl_wdata)) else $error("write lost");
  chk_timer_pick: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R08
    !tx_sel && timer_two_control_reg[`UBSS_BIT_T2_TCLK] |=>
    tx_rate_tick_out == $past(timer2_overflow_in)) else $error("timer pick wrong");
  // ----------------------------------------
  // check helpers
  // ----------------------------------------
  // cycles since the last generator tick; held at zero while halted, saturates at 255 while running
  logic [7:0] gen_gap_reg;
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      gen_gap_reg <= 8'h00;
    end else if (gen_tick || !run) begin
      gen_gap_reg <= 8'h00;
    end else if (gen_gap_reg != 8'hff) begin
      gen_gap_reg <= gen_gap_reg + 8'h01;
    end
  end
  // ----------------------------------------
  // bus checks
  // ----------------------------------------
  sequence s_request_taken;
    (state_reg == ubss_pkg::UBSS_IDLE) && access;
  endsequence
  sequence s_answer_seen;
    !avs_waitrequest_out;
  endsequence
  sequence s_lane_dropped;
    accept && avs_write_in && !avs_byteenable_in[0];
  endsequence
  // the answer time is fixed, masters may rely on it but need not
  chk_answer_time: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R07
    s_request_taken |-> ##2 s_answer_seen) else $error("answer not in two cycles");
  chk_wait_single: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R07
    s_answer_seen |=> avs_waitrequest_out) else $error("waitrequest low too long");
  chk_read_idle: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R06
    avs_waitrequest_out |-> avs_readdata_out == 32'h0000_0000)
    else $error("read data outside answer");
  // a partial write would corrupt the byte, so it is refused whole
  chk_lane_drop: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R07
    s_lane_dropped |=> $stable(control_reg)) else $error("partial write landed");
  // ----------------------------------------
  // rate checks
  // ----------------------------------------
  // a range change may cut one period short, so only a settled range is checked
  chk_slow_period: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R03
    run && !$past(speed) && gen_tick |-> gen_gap_reg >= 8'd95)
    else $error("slow period short");
  chk_x2_div: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R04
    osc_tick && double_speed_mode && $past(double_speed_mode) |=> !osc_tick [*5])
    else $error("double speed division wrong");
  chk_shift_osc: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R04
    !shift_sel && osc_tick |=> shift_clock_tick_out) else $error("shift osc source wrong");
  chk_tx_gen: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R02
    tx_sel && gen_tick |=> tx_rate_tick_out) else $error("tx generator source wrong");
  chk_rx_timer: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R08
    !rx_sel && !timer_two_control_reg[`UBSS_BIT_T2_RCLK] |=>
    rx_rate_tick_out == $past(timer1_overflow_in)) else $error("rx timer pick wrong");
  chk_gen_out: assert property (@(posedge clock_in) disable iff (sys_rst_in) // R01
    rate_gen_tick_out == $past(gen_tick)) else $error("generator output lost");
endmodule : ubss_top

/* testbench/uart_baud_source_select_tb.sv */
`timescale 1ns/1ps
`include "ubss_regs.svh"
module uart_baud_source_select_tb;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] rdata;
  logic wreq;
  logic t1 = 1'b0;
  logic t2 = 1'b0;
  logic [3:0] tk;
  logic [31:0] q;
  logic [1:0] s;
  int c;
  int err_total = 0;
  int cmp_count = 0;
  always #2 clock_in = ~clock_in;
  ubss_top u_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .timer1_overflow_in(t1),
    .timer2_overflow_in(t2), .tx_rate_tick_out(tk[0]), .rx_rate_tick_out(tk[1]),
    .shift_clock_tick_out(tk[2]), .rate_gen_tick_out(tk[3]));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task complete_run;
    $display("mismatches %0d of %0d compares", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // strobe held until waitrequest is seen low; data taken while it stands
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] b);
    int n;
    @(posedge clock_in);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdata <= {24'h0, d};
    be <= b;
    for (n = 0; n < 64; n++) begin
      @(posedge clock_in);
      if (wreq === 1'b0) break;
    end
    if (n == 64) begin
      err_total++;
      complete_run();
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  // cycles to the next pulse on one tick output
  task gap(input int i, output int n);
    n = 0;
    do begin
      @(negedge clock_in);
      n++;
    end while (tk[i] !== 1'b1 && n < 300);
    if (n >= 300) begin
      err_total++;
      complete_run();
    end
  endtask : gap
  task quiet(input int i, output int n);
    n = 0;
    repeat (200) begin
      @(negedge clock_in);
      if (tk[i] !== 1'b0) n++;
    end
  endtask : quiet
  task pulse(input logic which, output logic [1:0] seen);
    @(posedge clock_in);
    if (which) t2 <= 1'b1; else t1 <= 1'b1;
    @(posedge clock_in);
    t1 <= 1'b0;
    t2 <= 1'b0;
    @(negedge clock_in);
    seen = tk[1:0];
  endtask : pulse
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    bus(1'b0, `UBSS_BAUD_RATE_CONTROL_OFS, 8'h00, 4'h0);
    check(q, 32'h0);
    bus(1'b1, `UBSS_BAUD_RATE_CONTROL_OFS, 8'h1f, 4'h1);
    bus(1'b1, `UBSS_BAUD_RATE_CONTROL_OFS, 8'h00, 4'he);
    bus(1'b0, `UBSS_BAUD_RATE_CONTROL_OFS, 8'h00, 4'h0);
    check(q, 32'h1f);
    bus(1'b0, `UBSS_STATUS_OFS, 8'h00, 4'h0);
    check(q, 32'h3d);
    bus(1'b0, 8'h10, 8'h00, 4'h0);
    check(q, 32'h0);
    // skip the first gap: it is counted from mid-period, not from a pulse
    gap(3, c);
    gap(3, c);
    check(c, `UBSS_FAST_DIV);
    gap(2, c);
    gap(2, c);
    check(c, `UBSS_FAST_DIV);
    gap(0, c);
    gap(0, c);
    check(c, `UBSS_FAST_DIV);
    bus(1'b1, `UBSS_BAUD_RATE_CONTROL_OFS, 8'h11, 4'h1);
    gap(3, c);
    gap(3, c);
    check(c, `UBSS_SLOW_DIV);
    bus(1'b1, `UBSS_BAUD_RATE_CONTROL_OFS, 8'h01, 4'h1);
    quiet(3, c);
    check(c, 0);
    quiet(2, c);
    check(c, 0);
    bus(1'b1, `UBSS_BAUD_RATE_CONTROL_OFS, 8'h00, 4'h1);
    gap(2, c);
    gap(2, c);
    check(c, `UBSS_OSC_DIV);
    bus(1'b1, `UBSS_TIMER_TWO_CONTROL_OFS, 8'h01, 4'h1);
    gap(2, c);
    gap(2, c);
    check(c, `UBSS_X2_DIV);
    bus(1'b1, `UBSS_TIMER_TWO_CONTROL_OFS, 8'h20, 4'h1);
    bus(1'b1, `UBSS_BAUD_RATE_CONTROL_OFS, 8'h08, 4'h1);
    pulse(1'b1, s);
    check(s, 2'b10);
    pulse(1'b0, s);
    check(s, 2'b00);
    bus(1'b1, `UBSS_TIMER_TWO_CONTROL_OFS, 8'h00, 4'h1);
    bus(1'b1, `UBSS_BAUD_RATE_CONTROL_OFS, 8'h04, 4'h1);
    pulse(1'b0, s);
    check(s, 2'b01);
    complete_run();
  end
endmodule : uart_baud_source_select_tb
